// >>> hw/lies_cfg.svh
// Purpose: Offsets, bit positions and reset values of the line unit event block
// Assumes: 16-bit byte address, 8-bit registers
// Notes:   Included by every design file of the block
`ifndef LIES_CFG_SVH
`define LIES_CFG_SVH

`define LIES_AW             16
`define LIES_DW             8

`define LIES_OFS_ENABLE     16'h0f04
`define LIES_OFS_LIVE       16'h0f05
`define LIES_OFS_CHANGE     16'h0f06
`define LIES_OFS_IRQ_STAT   16'h0f10
`define LIES_OFS_MODE       16'h0f11

`define LIES_BIT_PLOCK      0
`define LIES_BIT_LOSS       1
`define LIES_BIT_LOOP       3
`define LIES_BIT_FIFO       5
`define LIES_BIT_DRIVE      6
`define LIES_BIT_SRAIL      0

`define LIES_EVENT_MASK     8'h6b
`define LIES_RST_BYTE       8'h00
`define LIES_RST_BIT        1'b0
`define LIES_ONE_BIT        1'b1

`endif

// >>> hw/lies_pkg.sv
// Purpose: State types of the line unit event block
// Assumes: Constants come from lies_cfg.svh
// Notes:   One packed struct per module holds all of its state
`include "lies_cfg.svh"

package lies_pkg;

    typedef logic [`LIES_AW-1:0] lies_addr_t;
    typedef logic [`LIES_DW-1:0] lies_byte_t;

    typedef struct packed {
        lies_byte_t enable;
        lies_byte_t irq_status;
        logic       single_rail;
        lies_byte_t rd_data;
        logic       irq;
    } lies_top_state_t;

    typedef struct packed {
        logic prev;
        logic flag;
    } lies_flag_state_t;

endpackage : lies_pkg

// >>> hw/lies_sync.sv
// Purpose: Two-stage synchroniser for a vector of level inputs
// Assumes: Each bit is an independent slow level
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
`include "lies_cfg.svh"

module lies_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } lies_sync_state_t;

    lies_sync_state_t state;
    lies_sync_state_t next_state;

    always_comb
    begin
        next_state.meta   = async_in;
        next_state.stable = state.meta;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign sync_out = state.stable;

endmodule : lies_sync
`default_nettype wire

// >>> hw/lies_change_bit.sv
// Purpose: One change flag that latches any transition of a live status bit
// Assumes: sample is already synchronised to clk_sys
// Notes:   A transition in the clearing cycle keeps the flag set
`timescale 1ns/1ns
`default_nettype none
`include "lies_cfg.svh"

module lies_change_bit
    import lies_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Control
    input  wire logic sample,
    input  wire logic active,
    input  wire logic clear,
    // Results
    output logic      changed,
    output logic      flag
);
    lies_flag_state_t state;
    lies_flag_state_t next_state;

    always_comb
    begin
        // Tracking runs even when inactive, so enabling raises no false edge
        next_state.prev = sample;
        changed         = active && (sample != state.prev);
        if (changed)
        begin
            next_state.flag = `LIES_ONE_BIT;
        end
        else if (clear)
        begin
            next_state.flag = `LIES_RST_BIT;
        end
        else
        begin
            next_state.flag = state.flag;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign flag = state.flag;

endmodule : lies_change_bit
`default_nettype wire

// >>> hw/lies_top.sv
// Purpose: Live status and change-flag registers of the line interface unit
// Assumes: Host register port on clk_sys; status levels from line-side detectors
// Notes:   Status inputs are synchronised; all outputs are registered
//
// Operation
// - Live bit 0 shows pattern lock
// - Pattern lock transitions interrupt when enabled
// - Live and change registers work only in single-rail mode
// - Flag bit 6 on drive-monitor change
// - Flag bit 5 on FIFO-limit change
// - Flag bit 3 on loop-code change
// - Flag bit 1 on signal-loss change
// - Flag bit 0 on pattern-lock change
// - Reading change register clears flags; reset zero
// - Change bits 7, 4, 2 read zero
// - Flag sits at its live bit position
// - Live bit 1 shows loss of signal
`timescale 1ns/1ns
`default_nettype none
`include "lies_cfg.svh"

module lies_top (
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst,
    // Register port
    input  wire lies_pkg::lies_addr_t addr,
    input  wire lies_pkg::lies_byte_t wr_data,
    input  wire logic            wr_en,
    input  wire logic            rd_en,
    output lies_pkg::lies_byte_t rd_data,
    // Live status from line detectors
    input  wire logic            drive_monitor_status,
    input  wire logic            fifo_limit_status,
    input  wire logic            loop_code_status,
    input  wire logic            signal_loss_status,
    input  wire logic            pattern_lock_status,
    // Interrupt
    output logic                 irq
);
    import lies_pkg::*;

    localparam lies_byte_t EVT_MASK = `LIES_EVENT_MASK;

    lies_top_state_t state;
    lies_top_state_t next_state;

    lies_byte_t raw_live;
    lies_byte_t live;
    lies_byte_t changed;
    lies_byte_t flags;

    logic       sel_enable;
    logic       sel_live;
    logic       sel_change;
    logic       sel_irq_stat;
    logic       sel_mode;

    logic       wr_enable;
    logic       wr_irq_stat;
    logic       wr_mode;
    logic       rd_change;

    lies_byte_t irq_clear;
    lies_byte_t next_rd;

    // Live vector in register layout; unused positions stay low
    always_comb
    begin
        raw_live = `LIES_RST_BYTE;
        raw_live[`LIES_BIT_PLOCK] = pattern_lock_status;
        raw_live[`LIES_BIT_LOSS]  = signal_loss_status;
        raw_live[`LIES_BIT_LOOP]  = loop_code_status;
        raw_live[`LIES_BIT_FIFO]  = fifo_limit_status;
        raw_live[`LIES_BIT_DRIVE] = drive_monitor_status;
    end

    // Detectors run from the recovered line timing, so resample here
    lies_sync #(
        .W (`LIES_DW)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (raw_live),
        .sync_out (live)
    );

    // Address decode
    assign sel_enable   = (addr == `LIES_OFS_ENABLE);
    assign sel_live     = (addr == `LIES_OFS_LIVE);
    assign sel_change   = (addr == `LIES_OFS_CHANGE);
    assign sel_irq_stat = (addr == `LIES_OFS_IRQ_STAT);
    assign sel_mode     = (addr == `LIES_OFS_MODE);

    assign wr_enable    = wr_en && sel_enable;
    assign wr_irq_stat  = wr_en && sel_irq_stat;
    assign wr_mode      = wr_en && sel_mode;

    assign rd_change    = rd_en && sel_change && state.single_rail;

    // One change latch per monitored bit
    genvar gi;
    generate
        for (gi = 0; gi < `LIES_DW; gi++)
        begin : g_bit
            if (EVT_MASK[gi])
            begin : g_used
                lies_change_bit u_flag (
                    .clk_sys (clk_sys),
                    .rst     (rst),
                    .sample  (live[gi]),
                    .active  (state.single_rail),
                    .clear   (rd_change),
                    .changed (changed[gi]),
                    .flag    (flags[gi])
                );
            end
            else
            begin : g_unused
                assign changed[gi] = `LIES_RST_BIT;
                assign flags[gi]   = `LIES_RST_BIT;
            end
        end
    endgenerate

    // Write-one-to-clear mask for the interrupt status
    assign irq_clear = wr_irq_stat ? wr_data : `LIES_RST_BYTE;

    // Read multiplexer; unmapped addresses return zero
    always_comb
    begin
        next_rd = `LIES_RST_BYTE;
        if (rd_en)
        begin
            if (sel_enable)
            begin
                next_rd = state.enable;
            end
            else if (sel_live)
            begin
                next_rd = state.single_rail ? (live & EVT_MASK) : `LIES_RST_BYTE;
            end
            else if (sel_change)
            begin
                next_rd = state.single_rail ? flags : `LIES_RST_BYTE;
            end
            else if (sel_irq_stat)
            begin
                next_rd = state.irq_status;
            end
            else if (sel_mode)
            begin
                next_rd                 = `LIES_RST_BYTE;
                next_rd[`LIES_BIT_SRAIL] = state.single_rail;
            end
            else
            begin
                next_rd = `LIES_RST_BYTE;
            end
        end
    end

    // Next-state logic
    always_comb
    begin
        next_state = state;

        // Only monitored positions can be enabled
        if (wr_enable)
        begin
            next_state.enable = wr_data & EVT_MASK;
        end

        if (wr_mode)
        begin
            next_state.single_rail = wr_data[`LIES_BIT_SRAIL];
        end

        next_state.irq_status = (state.irq_status & ~irq_clear) | changed;

        next_state.irq = |(next_state.irq_status & next_state.enable)
                         && next_state.single_rail;

        next_state.rd_data = next_rd;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign rd_data = state.rd_data;
    assign irq     = state.irq;

endmodule : lies_top
`default_nettype wire

// >>> tb/lies_props.sv
// Purpose: Port assertions for lies_top
// Assumes: One clock, async active-high reset
// Notes:   Bound below; sees only top ports
`timescale 1ns/1ns
`default_nettype none
module lies_props (
    // Clock and reset
    input wire logic                 clk_sys,
    input wire logic                 rst,
    // Register port
    input wire lies_pkg::lies_addr_t addr,
    input wire lies_pkg::lies_byte_t wr_data,
    input wire logic                 wr_en,
    input wire logic                 rd_en,
    input wire lies_pkg::lies_byte_t rd_data,
    // Status and interrupt
    input wire logic                 drive_monitor_status,
    input wire logic                 fifo_limit_status,
    input wire logic                 loop_code_status,
    input wire logic                 signal_loss_status,
    input wire logic                 pattern_lock_status,
    input wire logic                 irq
);
    import lies_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [4:0] st_q;
    logic [2:0] quiet;
    wire  [4:0] st = {drive_monitor_status, fifo_limit_status, loop_code_status,
                      signal_loss_status, pattern_lock_status};
    // Quiet time lets a read be judged only once the synchroniser has settled
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_q  <= 5'h00;
            quiet <= 3'h0;
        end
        else
        begin
            st_q  <= st;
            quiet <= (st != st_q) ? 3'h0 : ((quiet == 3'h7) ? quiet : quiet + 3'h1);
        end
    end
    a_reset_quiet: assert property ($fell(rst) |-> !irq && rd_data == 8'h00)
        else $error("busy after reset");
    a_rdata_idle: assert property (!$past(rd_en) |-> rd_data == 8'h00)
        else $error("rd_data without read");
    a_change_reserved: assert property ($past(rd_en) && $past(addr) == 16'h0f06 |-> (rd_data & 8'h94) == 8'h00)
        else $error("change spare bits set");
    a_live_reserved: assert property ($past(rd_en) && $past(addr) == 16'h0f05 |-> (rd_data & 8'h94) == 8'h00)
        else $error("live spare bits set");
    a_read_clears: assert property ($past(rd_en, 2) && $past(addr, 2) == 16'h0f06 && $past(rd_en)
        && $past(addr) == 16'h0f06 && quiet >= 3'h6 |-> rd_data == 8'h00) else $error("flags not cleared");
    a_lock_live: assert property ($past(rd_en) && $past(addr) == 16'h0f05 && rd_data[0] |->
        $past(pattern_lock_status, 2) || $past(pattern_lock_status, 3) || $past(pattern_lock_status, 4))
        else $error("lock bit without lock");
    a_loss_live: assert property ($past(rd_en) && $past(addr) == 16'h0f05 && rd_data[1] |->
        $past(signal_loss_status, 2) || $past(signal_loss_status, 3) || $past(signal_loss_status, 4))
        else $error("loss bit without loss");
    a_mask_off: assert property (wr_en && addr == 16'h0f04 && wr_data == 8'h00 ##1 !wr_en |-> ##1 !irq)
        else $error("irq with all masked");
    c_irq: cover property ($rose(irq));
    c_clear: cover property ($past(rd_en) && $past(addr) == 16'h0f06 && rd_data != 8'h00);
    c_live: cover property ($past(rd_en) && $past(addr) == 16'h0f05 && rd_data[0]);
endmodule : lies_props
bind lies_top lies_props i_props (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .drive_monitor_status(drive_monitor_status),
    .fifo_limit_status(fifo_limit_status), .loop_code_status(loop_code_status),
    .signal_loss_status(signal_loss_status), .pattern_lock_status(pattern_lock_status), .irq(irq));
`default_nettype wire

// >>> tb/lies_top_test.sv
// Purpose: Register-level test of lies_top
// Assumes: Flags settle within 6 cycles of a status edge
// Notes:   Status inputs form one vector at their live bit positions
`timescale 1ns/1ns
`default_nettype none
module lies_top_test;
    import lies_pkg::*;
    logic       clk_sys;
    logic       rst;
    lies_addr_t addr;
    lies_byte_t wr_data;
    logic       wr_en;
    logic       rd_en;
    lies_byte_t rd_data;
    logic       irq;
    lies_byte_t st;
    int         err_total;
    int         n_compared;
    int         pos [5] = '{6, 5, 3, 1, 0};
    lies_top i_dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .drive_monitor_status(st[6]), .fifo_limit_status(st[5]),
        .loop_code_status(st[3]), .signal_loss_status(st[1]), .pattern_lock_status(st[0]), .irq(irq));
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string what, input lies_byte_t got, input lies_byte_t exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("MISMATCH %s exp %h got %h", what, exp, got);
            err_total++;
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic wr(input lies_addr_t a, input lies_byte_t d);
        @(posedge clk_sys);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input lies_addr_t a, input lies_byte_t e);
        @(posedge clk_sys);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk("rd_data", rd_data, e);
    endtask : rd
    // Back-to-back change reads: the second must find nothing left
    task automatic rd2(input lies_byte_t e);
        @(posedge clk_sys);
        addr  <= 16'h0f06;
        rd_en <= 1'b1;
        tick(1);
        chk("first flags", rd_data, e);
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk("second flags", rd_data, 8'h00);
    endtask : rd2
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    initial
    begin
        rst        = 1'b1;
        addr       = 16'h0000;
        wr_data    = 8'h00;
        wr_en      = 1'b0;
        rd_en      = 1'b0;
        st         = 8'h00;
        err_total  = 0;
        n_compared = 0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rd(16'h0f06, 8'h00);
        st[0] <= 1'b1;
        tick(6);
        rd(16'h0f05, 8'h00);
        rd(16'h0f06, 8'h00);
        st[0] <= 1'b0;
        tick(6);
        wr(16'h0f11, 8'h01);
        wr(16'h0f04, 8'hff);
        rd(16'h0f04, 8'h6b);
        rd(16'h0f06, 8'h00);
        rd(16'h0f07, 8'h00);
        // Status edge timed so its flag sets on the clearing read's edge
        @(posedge clk_sys);
        st[0] <= 1'b1;
        @(posedge clk_sys);
        rd(16'h0f06, 8'h00);
        rd(16'h0f06, 8'h01);
        st[0] <= 1'b0;
        tick(6);
        rd2(8'h01);
        wr(16'h0f10, 8'hff);
        foreach (pos[i])
        begin
            st[pos[i]] <= 1'b1;
            tick(6);
            rd(16'h0f05, 8'h01 << pos[i]);
            rd2(8'h01 << pos[i]);
            chk("irq", {7'h00, irq}, 8'h01);
            wr(16'h0f10, 8'hff);
            tick(2);
            chk("irq", {7'h00, irq}, 8'h00);
            st[pos[i]] <= 1'b0;
            tick(6);
            rd(16'h0f05, 8'h00);
            rd2(8'h01 << pos[i]);
            chk("irq", {7'h00, irq}, 8'h01);
            wr(16'h0f10, 8'hff);
        end
        wr(16'h0f04, 8'h00);
        st <= 8'h6b;
        tick(6);
        chk("irq", {7'h00, irq}, 8'h00);
        rd(16'h0f05, 8'h6b);
        rd2(8'h6b);
        wr(16'h0f04, 8'h01);
        tick(1);
        chk("irq", {7'h00, irq}, 8'h01);
        rd(16'h0f10, 8'h6b);
        wr(16'h0f11, 8'h00);
        tick(1);
        chk("irq", {7'h00, irq}, 8'h00);
        rd(16'h0f05, 8'h00);
        summarize();
    end
endmodule : lies_top_test
`default_nettype wire
